// *** include/fia_pkg.sv ***
// package for the flash in-application access control block
package fia_pkg;
  localparam logic [7:0] FIA_CMD_ADDR = 8'h97;
  localparam logic [7:0] FIA_IE1_ADDR = 8'ha9;
  localparam logic [7:0] FIA_CFGL_SFR_ADDR = 8'hf7;
  localparam logic [7:0] FIA_CMD_ALL = 8'h65;
  localparam logic [7:0] FIA_CMD_SOFT_RESET_COMMAND = 8'h56;
  localparam logic [2:0] FIA_WE_KEY = 3'h5;
  localparam int FIA_WE_LSB = 5;
  localparam int FIA_LOCK_BIT = 1;
  localparam logic [15:0] FIA_LOCK_END = 16'h01ff;
  localparam logic [15:0] FIA_ALL_END = 16'h1eff;
  localparam logic [15:0] FIA_FREE_END = 16'h1ffd;
  localparam logic [15:0] FIA_CFGL_ADDR = 16'h1ffe;
  localparam logic [15:0] FIA_CFGH_ADDR = 16'h1fff;
  localparam logic [15:0] FIA_EXPANSION_DATA_RAM_BASE = 16'hff00;
  localparam logic [7:0] FIA_IE1_RST = 8'h00;
  localparam logic [7:0] FIA_CFGL_RST = 8'h00;
  localparam int FIA_CLK_HZ = 40000000;
  localparam int FIA_WRITE_US = 500;
  localparam int FIA_WARMUP_MS = 40;
  localparam int FIA_WRITE_CYC = FIA_WRITE_US * (FIA_CLK_HZ / 1000000);
  localparam int FIA_WARMUP_CYC = FIA_WARMUP_MS * (FIA_CLK_HZ / 1000);

  typedef enum logic [1:0] {FIA_WARM, FIA_LOAD_L, FIA_LOAD_H, FIA_RUN} fia_phase_e;

  typedef struct packed {
    logic rd;
    logic wr;
    logic code;
    logic [15:0] addr;
    logic [7:0] wdata;
  } fia_acc_s;

  typedef struct packed {
    fia_phase_e phase;
    logic [20:0] cnt;
    logic all_area;
    logic [7:0] ie1;
    logic [7:0] cfg_low;
    logic [7:0] cfg_high;
    logic busy;
    logic soft_rst;
    logic por_done;
    logic [7:0] rdata;
    logic rvalid;
    logic denied;
    logic fl_we;
    logic fl_re;
    logic [15:0] fl_addr;
    logic [7:0] fl_wdata;
    logic expansion_data_ram_sel;
    logic sfr_rvalid;
    logic [7:0] sfr_rdata;
  } fia_state_s;
endpackage

// *** src/fia_ctrl.sv ***
// flash in-application access control: sector permissions, write gating, stall
// Behaviour
// R1 - lowest sector: lock 1 blocks all; lock 0 code ok, data only with all-area flag
// R2 - middle sector: code reads always; data access only with all-area flag
// R3 - writing 65h to command register sets all-area flag; other values clear it
// R4 - command register read returns all-area flag on bit 0, reset 0
// R5 - free data sector always accessible by code and data space
// R6 - low config byte: code read always; data access needs all-area flag
// R7 - high config byte: data access denied, code read allowed
// R8 - after power-on, low config byte copied into an SFR software may modify
// R9 - data-space write to flash address is a byte write of accumulator
// R10 - flash write accepted only when write-enable field is 101
// R11 - stall cpu about 500 us during a flash write
// R12 - interrupts arising during a write stay pending until cpu resumes
// R13 - flash reads by data or code space add no wait cycles
// R14 - software should clear write-enable and all-area flag after access
// R15 - data accesses FF00h-FFFFh go to expansion data ram
// R16 - writing 56h to command register generates a software reset
// R17 - power-on: 40 ms warm-up then load both config bytes; no reload otherwise
// R18 - any reset returns SFRs to defaults, access flags disabled; rstn leaves the cfg_low SFR unchanged
`timescale 1ns/1ps
`default_nettype none
module fia_ctrl
  import fia_pkg::*;
#(
  parameter int WRITE_CYC = FIA_WRITE_CYC,
  parameter int WARMUP_CYC = FIA_WARMUP_CYC
) (
  input wire logic clk, // system clock
  input wire logic rstn, // any reset, sync active low
  input wire logic por_n, // power-on reset, sync active low
  input wire fia_acc_s acc, // cpu flash/expansion_data_ram access request
  input wire logic sfr_wr, // sfr write strobe
  input wire logic sfr_rd, // sfr read strobe
  input wire logic [7:0] sfr_addr, // sfr address
  input wire logic [7:0] sfr_wdata, // sfr write data
  input wire logic [7:0] fl_rdata, // flash array read data
  input wire logic irq_in, // combined interrupt request
  output logic [7:0] sfr_rdata, // sfr read data
  output logic sfr_rvalid, // sfr read data valid
  output logic [7:0] rdata, // flash read data to cpu
  output logic rvalid, // flash read data valid
  output logic denied, // access refused pulse
  output logic cpu_wait, // cpu stall during flash write
  output logic irq_take, // interrupt allowed to cpu
  output logic soft_rst, // software reset pulse
  output logic fl_we, // flash byte write strobe
  output logic fl_re, // flash read strobe
  output logic [15:0] fl_addr, // flash address
  output logic [7:0] fl_wdata, // flash write data
  output logic expansion_data_ram_sel, // expansion ram select
  output logic [7:0] cfg_low, // config low byte sfr
  output logic [7:0] cfg_high // config high byte
);
  fia_state_s s_reg, s_next;
  logic in_flash, allow, lock;
  logic irq_hold_reg;

  always_comb begin
    lock = s_reg.cfg_high[FIA_LOCK_BIT];
    in_flash = (acc.addr <= FIA_CFGH_ADDR);
    if (acc.addr <= FIA_LOCK_END) begin
      allow = !lock && (acc.code || s_reg.all_area); // R1
    end else if (acc.addr <= FIA_ALL_END) begin
      allow = acc.code || s_reg.all_area; // R2
    end else if (acc.addr <= FIA_FREE_END) begin
      allow = 1'b1; // R5
    end else if (acc.addr == FIA_CFGL_ADDR) begin
      allow = acc.code || s_reg.all_area; // R6
    end else begin
      allow = acc.code; // R7
    end
  end

  always_comb begin
    s_next = s_reg;
    s_next.rvalid = 1'b0;
    s_next.denied = 1'b0;
    s_next.fl_we = 1'b0;
    s_next.fl_re = 1'b0;
    s_next.soft_rst = 1'b0;
    s_next.sfr_rvalid = 1'b0;
    s_next.expansion_data_ram_sel = 1'b0;
    unique case (s_reg.phase)
      FIA_WARM: begin
        s_next.busy = 1'b1;
        if (s_reg.cnt >= 21'(WARMUP_CYC - 1)) begin
          s_next.phase = FIA_LOAD_L;
          s_next.cnt = '0;
          s_next.fl_re = 1'b1;
          s_next.fl_addr = FIA_CFGL_ADDR;
        end else begin
          s_next.cnt = s_reg.cnt + 21'h1;
        end
      end
      FIA_LOAD_L: begin
        s_next.cfg_low = fl_rdata; // R8 R17
        s_next.fl_re = 1'b1;
        s_next.fl_addr = FIA_CFGH_ADDR;
        s_next.phase = FIA_LOAD_H;
      end
      FIA_LOAD_H: begin
        s_next.cfg_high = fl_rdata; // R17
        s_next.phase = FIA_RUN;
        s_next.busy = 1'b0;
        s_next.por_done = 1'b1;
      end
      FIA_RUN: begin
        if (s_reg.busy) begin
          if (s_reg.cnt >= 21'(WRITE_CYC - 1)) begin
            s_next.busy = 1'b0; // R11
            s_next.cnt = '0;
          end else begin
            s_next.cnt = s_reg.cnt + 21'h1;
          end
        end else begin
          if (sfr_wr && sfr_addr == FIA_CMD_ADDR) begin
            s_next.all_area = (sfr_wdata == FIA_CMD_ALL); // R3
            s_next.soft_rst = (sfr_wdata == FIA_CMD_SOFT_RESET_COMMAND); // R16
          end
          if (sfr_wr && sfr_addr == FIA_IE1_ADDR) begin
            s_next.ie1 = sfr_wdata;
          end
          if (sfr_wr && sfr_addr == FIA_CFGL_SFR_ADDR) begin
            s_next.cfg_low = sfr_wdata; // R8
          end
          if (sfr_rd) begin
            s_next.sfr_rvalid = 1'b1;
            unique case (sfr_addr)
              FIA_CMD_ADDR: s_next.sfr_rdata = {7'h00, s_reg.all_area}; // R4
              FIA_IE1_ADDR: s_next.sfr_rdata = s_reg.ie1;
              FIA_CFGL_SFR_ADDR: s_next.sfr_rdata = s_reg.cfg_low;
              default: s_next.sfr_rdata = 8'h00;
            endcase
          end
          if ((acc.rd || acc.wr) && !acc.code && acc.addr >= FIA_EXPANSION_DATA_RAM_BASE) begin
            s_next.expansion_data_ram_sel = 1'b1; // R15
          end else if (acc.rd && in_flash) begin
            s_next.fl_addr = acc.addr;
            if (allow) begin
              s_next.fl_re = 1'b1; // R13
            end else begin
              s_next.denied = 1'b1;
            end
          end else if (acc.wr && !acc.code && acc.addr < FIA_CFGH_ADDR) begin
            if (allow && s_reg.ie1[FIA_WE_LSB+:3] == FIA_WE_KEY) begin // R10
              s_next.fl_we = 1'b1; // R9
              s_next.fl_addr = acc.addr;
              s_next.fl_wdata = acc.wdata;
              s_next.busy = 1'b1; // R11
              s_next.cnt = '0;
            end else begin
              s_next.denied = 1'b1;
            end
          end else if (acc.wr && !acc.code && acc.addr == FIA_CFGH_ADDR) begin
            s_next.denied = 1'b1; // R7
          end
        end
        if (s_reg.fl_re) begin
          s_next.rvalid = 1'b1;
          s_next.rdata = fl_rdata;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!por_n) begin
      s_reg <= '0;
      s_reg.phase <= FIA_WARM;
      s_reg.busy <= 1'b1;
    end else if (!rstn) begin
      // config bytes kept; a power-on load still in progress runs on
      if (s_reg.por_done) begin
        s_reg.busy <= 1'b0;
        s_reg.cnt <= '0;
        s_reg.rvalid <= 1'b0;
        s_reg.denied <= 1'b0;
        s_reg.fl_we <= 1'b0;
        s_reg.fl_re <= 1'b0;
        s_reg.soft_rst <= 1'b0;
        s_reg.sfr_rvalid <= 1'b0;
        s_reg.expansion_data_ram_sel <= 1'b0;
      end else begin
        s_reg <= s_next; // R17
      end
      s_reg.all_area <= 1'b0; // R18
      s_reg.ie1 <= FIA_IE1_RST; // R18
    end else begin
      s_reg <= s_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn || !por_n) begin
      irq_hold_reg <= 1'b0;
    end else begin
      irq_hold_reg <= irq_in && !s_next.busy; // R12
    end
  end

  always_comb begin
    sfr_rdata = s_reg.sfr_rdata;
    sfr_rvalid = s_reg.sfr_rvalid;
    rdata = s_reg.rdata;
    rvalid = s_reg.rvalid;
    denied = s_reg.denied;
    cpu_wait = s_reg.busy; // R11
    irq_take = irq_hold_reg; // R12
    soft_rst = s_reg.soft_rst;
    fl_we = s_reg.fl_we;
    fl_re = s_reg.fl_re;
    fl_addr = s_reg.fl_addr;
    fl_wdata = s_reg.fl_wdata;
    expansion_data_ram_sel = s_reg.expansion_data_ram_sel;
    cfg_low = s_reg.cfg_low;
    cfg_high = s_reg.cfg_high;
  end
endmodule // fia_ctrl
`default_nettype wire

// *** sim/fia_props.sv ***
// assertions on the flash access control ports
`timescale 1ns/1ps
`default_nettype none
module fia_props
  import fia_pkg::*;
(
  input wire logic clk, // clock
  input wire logic rstn, // reset
  input wire logic por_n, // power-on reset
  input wire fia_acc_s acc, // access
  input wire logic sfr_wr, // sfr write
  input wire logic sfr_rd, // sfr read
  input wire logic [7:0] sfr_addr, // sfr address
  input wire logic [7:0] sfr_wdata, // sfr data
  input wire logic sfr_rvalid, // sfr answer
  input wire logic rvalid, // read answer
  input wire logic denied, // refusal
  input wire logic cpu_wait, // stall
  input wire logic irq_take, // irq out
  input wire logic soft_rst, // soft reset
  input wire logic fl_we, // flash write
  input wire logic expansion_data_ram_sel // ram select
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn || !por_n);
  wire dacc = (acc.rd | acc.wr) & !acc.code & !cpu_wait;
  cfgh_deny_a: assert property (dacc && acc.addr == FIA_CFGH_ADDR |=> denied && !fl_we)
    else $error("high config byte data access not refused");
  free_open_a: assert property (dacc && acc.rd
    && acc.addr inside {[FIA_ALL_END + 16'h1:FIA_FREE_END]}
    |=> !denied ##1 rvalid) else $error("free sector read not answered");
  expansion_data_ram_route_a: assert property (dacc && acc.addr >= FIA_EXPANSION_DATA_RAM_BASE |=> expansion_data_ram_sel && !denied)
    else $error("ram window access not routed");
  soft_reset_command_pulse_a: assert property (sfr_wr && !cpu_wait && sfr_addr == FIA_CMD_ADDR
    && sfr_wdata == FIA_CMD_SOFT_RESET_COMMAND |=> soft_rst) else $error("soft reset not pulsed");
  write_stall_a: assert property (fl_we |=> cpu_wait [*8])
    else $error("cpu not held during flash write");
  irq_hold_a: assert property (fl_we |=> ##1 !irq_take [*4])
    else $error("interrupt passed during flash write");
  code_read_a: assert property (acc.rd && acc.code && !cpu_wait && acc.addr == FIA_CFGH_ADDR
    |-> ##2 rvalid && !cpu_wait) else $error("code read not answered in time");
  sfr_answer_a: assert property (sfr_rd && !cpu_wait |=> sfr_rvalid)
    else $error("sfr read not answered");
  cover property (fl_we);
  cover property (soft_rst);
  cover property (denied);
endmodule // fia_props
bind fia_ctrl fia_props i_fia_props (.clk(clk), .rstn(rstn), .por_n(por_n), .acc(acc),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
  .sfr_rvalid(sfr_rvalid), .rvalid(rvalid), .denied(denied), .cpu_wait(cpu_wait),
  .irq_take(irq_take), .soft_rst(soft_rst), .fl_we(fl_we), .expansion_data_ram_sel(expansion_data_ram_sel));
`default_nettype wire

// *** sim/fia_flash_model.sv ***
// flash array model behind the access controller
`timescale 1ns/1ps
`default_nettype none
module fia_flash_model (
  input wire logic clk, // clock
  input wire logic fl_re, // read strobe
  input wire logic fl_we, // write strobe
  input wire logic [15:0] fl_addr, // address
  input wire logic [7:0] fl_wdata, // write data
  output logic [7:0] fl_rdata // read data
);
  logic [7:0] mem [0:8191];
  initial begin
    for (int i = 0; i < 8192; i++) mem[i] = i[7:0] ^ 8'h3c;
  end
  always @(posedge clk) begin
    if (fl_we) mem[fl_addr[12:0]] <= fl_wdata;
  end
  // data only while the read strobe stands, inverted otherwise
  assign fl_rdata = fl_re ? mem[fl_addr[12:0]] : ~mem[fl_addr[12:0]];
endmodule // fia_flash_model
`default_nettype wire

// *** sim/fia_ctrl_tb.sv ***
// self-checking bench for the flash access control block
`timescale 1ns/1ps
`default_nettype none
module fia_ctrl_tb;
  import fia_pkg::*;
  logic clk = 0, rstn = 0, por_n = 0, sfr_wr = 0, sfr_rd = 0, irq_in = 0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, fl_rdata, sfr_rdata, rdata, cfg_low, cfg_high;
  logic sfr_rvalid, rvalid, denied, cpu_wait, irq_take, soft_rst, fl_we, fl_re, expansion_data_ram_sel;
  logic [15:0] fl_addr;
  logic [7:0] fl_wdata;
  fia_acc_s acc = '0;
  int failures = 0, comparisons = 0, aa = 0, key = 0, lock = 0;
  int sh [int];
  int tbl [6] = '{'h100, 'h300, 'h1f80, 'h1ffe, 'h1fff, 'hff10};
  localparam int WR_CYC = 10;
  always #12.5 clk = ~clk;
  fia_ctrl #(.WRITE_CYC(WR_CYC), .WARMUP_CYC(20)) i_fia_ctrl (.clk(clk), .rstn(rstn),
    .por_n(por_n),
    .acc(acc), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .fl_rdata(fl_rdata), .irq_in(irq_in), .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid),
    .rdata(rdata), .rvalid(rvalid), .denied(denied), .cpu_wait(cpu_wait), .irq_take(irq_take),
    .soft_rst(soft_rst), .fl_we(fl_we), .fl_re(fl_re), .fl_addr(fl_addr), .fl_wdata(fl_wdata),
    .expansion_data_ram_sel(expansion_data_ram_sel), .cfg_low(cfg_low), .cfg_high(cfg_high));
  fia_flash_model i_fia_flash_model (.clk(clk), .fl_re(fl_re), .fl_we(fl_we),
    .fl_addr(fl_addr), .fl_wdata(fl_wdata), .fl_rdata(fl_rdata));
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tally_and_finish();
    if (failures == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cyc();
    @(posedge clk);
    #1;
  endtask
  task automatic idle();
    for (int i = 0; i < 60 && cpu_wait !== 1'b0; i++) cyc();
    chk("cpu_wait", cpu_wait, 0);
  endtask
  function automatic int mv(int a);
    return sh.exists(a) ? sh[a] : (a ^ 'h3c) & 'hff;
  endfunction
  function automatic bit allowed(int a, bit c);
    if (a <= 'h1ff) return !lock && (c || aa);
    if (a <= 'h1eff || a == 'h1ffe) return c || aa;
    if (a <= 'h1ffd) return 1;
    return c;
  endfunction
  task automatic sw(input logic [7:0] a, input logic [7:0] d);
    {sfr_wr, sfr_addr, sfr_wdata} = {1'b1, a, d};
    cyc();
    sfr_wr = 0;
    chk("soft_rst", soft_rst, a == FIA_CMD_ADDR && d == FIA_CMD_SOFT_RESET_COMMAND);
    if (a == FIA_CMD_ADDR) aa = (d == FIA_CMD_ALL);
    if (a == FIA_IE1_ADDR) key = (d[7:5] == FIA_WE_KEY);
    cyc();
  endtask
  task automatic sr(input logic [7:0] a, input int e);
    {sfr_rd, sfr_addr} = {1'b1, a};
    cyc();
    sfr_rd = 0;
    chk("sfr_read", {sfr_rvalid, sfr_rdata}, {1'b1, 8'(e)});
    cyc();
  endtask
  task automatic ax(input bit wr, input bit c, input int a, input logic [7:0] d);
    bit ok;
    bit x;
    int n;
    x = a >= 'hff00;
    ok = x || allowed(a, c);
    acc = '{rd: !wr, wr: wr, code: c, addr: a[15:0], wdata: d};
    cyc();
    acc = '0;
    chk("we_expansion_data_ram", {fl_we, expansion_data_ram_sel}, {ok && wr && key && !x, x});
    chk("denied", denied, !ok || (wr && !key && !x));
    if (wr && ok && key && !x) begin
      sh[a] = d;
      irq_in = 1;
      cyc();
      chk("stall", {cpu_wait, irq_take}, 2'b10);
      for (n = 1; n < 60 && cpu_wait === 1'b1; n++) cyc();
      chk("stall_len", n, WR_CYC);
      idle();
      cyc();
      chk("irq_take", irq_take, 1);
      irq_in = 0;
    end else if (!wr && ok && !x) begin
      cyc();
      chk("read", {rvalid, cpu_wait, rdata}, {2'b10, 8'(mv(a))});
    end else begin
      cyc();
    end
  endtask
  initial begin
    void'($urandom(32'h5069103e));
    for (int l = 0; l < 2; l++) begin
      lock = l;
      sh['h1fff] = ($urandom & 'hfd) | (l << 1);
      {rstn, por_n, aa, key} = 0;
      repeat (3) cyc();
      i_fia_flash_model.mem['h1fff] = 8'(sh['h1fff]);
      {rstn, por_n} = 2'b11;
      idle();
      chk("cfg", {cfg_high, cfg_low}, {8'(mv('h1fff)), 8'(mv('h1ffe))});
      sr(FIA_CMD_ADDR, 0);
      for (int k = 0; k < 24; k++) begin
        if (k % 12 == 0) begin
          sw(FIA_CMD_ADDR, k ? FIA_CMD_ALL : 8'($urandom) | 8'h80);
          sr(FIA_CMD_ADDR, aa);
        end
        if (k % 12 != 11) ax(0, k % 2, tbl[(k / 2) % 6], 0);
      end
      sw(FIA_IE1_ADDR, 8'h60);
      ax(1, 0, 'h1f00 + l, 8'($urandom));
      sw(FIA_IE1_ADDR, 8'ha0);
      ax(1, 0, 'h1f00 + l, 8'($urandom));
      ax(0, 0, 'h1f00 + l, 0);
      ax(1, 0, 'h0100, 8'($urandom));
      sw(FIA_IE1_ADDR, 8'h00);
      ax(1, 0, 'h1fff, 8'h00);
      sw(FIA_CMD_ADDR, FIA_CMD_SOFT_RESET_COMMAND);
      sw(FIA_CMD_ADDR, FIA_CMD_ALL);
      {rstn, aa, key} = 0;
      cyc();
      rstn = 1;
      idle();
      sr(FIA_CMD_ADDR, 0);
      sr(FIA_IE1_ADDR, FIA_IE1_RST);
      chk("cfg_kept", cfg_low, mv('h1ffe));
      sw(FIA_CFGL_SFR_ADDR, 8'h5a + l);
      sr(FIA_CFGL_SFR_ADDR, 'h5a + l);
      chk("cfg_low", cfg_low, 'h5a + l);
      sr(8'h90, 0);
    end
    tally_and_finish();
  end
  initial begin
    #(25 * 5000);
    failures++;
    tally_and_finish();
  end
endmodule // fia_ctrl_tb
`default_nettype wire
